// [hw/pcm_port_cfg.svh]
/*
 * address map, reset values and line constants of the pcm port unit.
 * assumes a 16-bit dsp address and data bus.
 */
`ifndef PCM_PORT_CFG_SVH
`define PCM_PORT_CFG_SVH

// ==================================================
// dsp address window
`define BUF_PAGE 8'ha0
`define VALID_SET_BASE 16'ha100
`define VALID_CLR_BASE 16'ha108
`define PREFIX_ADDR 16'ha110
`define CTRL_ADDR 16'ha111

// ==================================================
// reset values
`define VALID_RST 16'h0000
`define PREFIX_RST 8'h00
`define CTRL_RST 4'h0
`define RDATA_NONE 16'h0000

// ==================================================
// line constants
`define SLOTS_4X32 9'h020
`define SLOTS_2X64 9'h040
`define SLOTS_1X128 9'h080
`define LAST_BIT 3'h7
`define CYC_MAX 12'hfff
`define CYC_ZERO 12'h000

`endif

// [hw/pcm_port_pkg.sv]
/*
 * types of the pcm port unit.
 * assumes pcm_port_cfg.svh for numbers.
 */
package pcm_port_pkg;

   typedef enum logic [1:0] {RATE_4X32, RATE_2X64, RATE_1X128, RATE_1X256} rate_t;

   typedef struct packed {
      logic half;
      logic dbl;
      rate_t rate;
   } ctrl_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsp_req_t;

   typedef struct packed {
      logic rvalid;
      logic [15:0] rdata;
   } dsp_rsp_t;

   typedef struct packed {
      logic act;
      logic [6:0] idx;
   } slot_map_t;

   typedef struct packed {
      logic [2:0] bclk_s;
      logic [2:0] fs_s;
      logic [3:0] rx_s1;
      logic [3:0] rx_s2;
      logic fs_prev;
      logic started;
      logic sel;
      logic [11:0] cyc;
      logic [3:0][7:0] rx_sh;
      logic [3:0] tx_d;
      logic [3:0] tx_oe;
      logic [3:0] tsc;
      logic [7:0][15:0] valid;
      logic [7:0] prefix;
      ctrl_t ctrl;
      dsp_rsp_t rsp;
   } state_t;

endpackage

// [hw/pcm_port_unit.sv]
/*
 * four-port pcm highway unit: serial slots to and from a swapped
 * pair of frame buffers, dsp window, slot-valid set/clear registers.
 * assumes bit clock, frame sync and receive pins are asynchronous
 * to clk and slower than clk/4; the dsp port is synchronous to clk.
 */
`timescale 1ns/1ps
`include "pcm_port_cfg.svh"

module pcm_port_unit
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic highway_bit_clock,
   input wire logic highway_frame_sync,
   input wire logic [3:0] serial_receive_in,
   output logic [3:0] serial_transmit_out,
   output logic [3:0] serial_transmit_oe,
   output logic [3:0] slot_enable_out_pin,
   input wire pcm_port_pkg::dsp_req_t dsp_req,
   output pcm_port_pkg::dsp_rsp_t dsp_rsp
);
   import pcm_port_pkg::*;

   // ==================================================
   // slot to buffer index and register bit
   function automatic slot_map_t slot_map(input rate_t m, input logic half,
                                          input logic [1:0] p, input logic [7:0] s);
      slot_map_t r;
      r.act = 1'b0;
      r.idx = 7'h00;
      unique case (m)
         RATE_4X32:
         begin
            r.act = ({1'b0, s} < `SLOTS_4X32);
            r.idx = {p, s[4:0]};
         end
         RATE_2X64:
         begin
            r.act = !p[0] && ({1'b0, s} < `SLOTS_2X64);
            r.idx = {p[1], s[5:0]};
         end
         RATE_1X128:
         begin
            r.act = (p == 2'h0) && ({1'b0, s} < `SLOTS_1X128);
            r.idx = s[6:0];
         end
         RATE_1X256:
         begin
            r.act = (p == 2'h0) && (s[7] == half);
            r.idx = s[6:0];
         end
      endcase
      return r;
   endfunction

   // ==================================================
   // dsp address decode, shared by reads and writes
   typedef enum logic [2:0] {TGT_NONE, TGT_BUF, TGT_SET, TGT_CLR, TGT_PREFIX, TGT_CTRL} tgt_t;

   function automatic tgt_t dsp_target(input logic [15:0] a);
      tgt_t t;
      t = TGT_NONE;
      if (a[15:8] == `BUF_PAGE)
         t = TGT_BUF;
      else if ({a[15:3], 3'h0} == `VALID_SET_BASE)
         t = TGT_SET;
      else if ({a[15:3], 3'h0} == `VALID_CLR_BASE)
         t = TGT_CLR;
      else if (a == `PREFIX_ADDR)
         t = TGT_PREFIX;
      else if (a == `CTRL_ADDR)
         t = TGT_CTRL;
      return t;
   endfunction

   // ==================================================
   // slot-valid bit that governs a buffer index
   function automatic logic valid_bit(input logic [7:0][15:0] v, input logic [6:0] i);
      return v[i[6:4]][i[3:0]];
   endfunction

   // ==================================================
   // frame buffer byte address: receive half or transmit half
   function automatic logic [7:0] buf_addr(input logic tx, input logic [6:0] i);
      return {tx, i};
   endfunction

   // ==================================================
   // state
   state_t q, d;
   logic [7:0] mem [0:1][0:255];
   logic [3:0] rx_we;
   logic [3:0][6:0] rx_wa;
   logic [3:0][7:0] rx_wd;
   logic dsp_we;
   logic rise, fall, dbl, in_range;
   logic [10:0] bit_idx;
   slot_map_t m;
   logic [7:0] tx_byte;
   logic [7:0] buf_byte;
   tgt_t tgt;
   logic [2:0] reg_sel;

   // ==================================================
   // next state
   always_comb
   begin
      d = q;
      rx_we = 4'h0;
      rx_wa = '0;
      rx_wd = '0;
      dsp_we = 1'b0;
      m = '0;
      tx_byte = 8'h00;
      d.bclk_s = {q.bclk_s[1:0], highway_bit_clock};
      d.fs_s = {q.fs_s[1:0], highway_frame_sync};
      d.rx_s1 = serial_receive_in;
      d.rx_s2 = q.rx_s1;
      rise = q.bclk_s[1] && !q.bclk_s[2];
      fall = !q.bclk_s[1] && q.bclk_s[2];
      dbl = q.ctrl.dbl && (q.ctrl.rate != RATE_1X256);
      bit_idx = dbl ? q.cyc[11:1] : q.cyc[10:0];
      in_range = q.started && (dbl || !q.cyc[11]);
      buf_byte = mem[~q.sel][dsp_req.addr[7:0]];
      tgt = dsp_target(dsp_req.addr);
      reg_sel = dsp_req.addr[2:0];

      // line: receive side and frame sync
      if (fall)
      begin
         d.fs_prev = q.fs_s[1];
         if (q.fs_s[1] && !q.fs_prev)
         begin
            d.cyc = `CYC_ZERO;
            d.sel = ~q.sel;
            d.started = 1'b1;
         end
         else
         begin
            if (in_range && (!dbl || q.cyc[0]))
            begin
               for (int p = 0; p < 4; p++)
               begin
                  m = slot_map(q.ctrl.rate, q.ctrl.half, 2'(p), bit_idx[10:3]);
                  d.rx_sh[p] = {q.rx_sh[p][6:0], q.rx_s2[p]};
                  if (m.act && (bit_idx[2:0] == `LAST_BIT))
                  begin
                     rx_we[p] = 1'b1;
                     rx_wa[p] = m.idx;
                     rx_wd[p] = {q.rx_sh[p][6:0], q.rx_s2[p]};
                  end
               end
            end
            if (q.cyc != `CYC_MAX)
               d.cyc = q.cyc + 12'h001;
         end
      end

      // line: transmit side
      if (rise && (!dbl || !q.cyc[0]))
      begin
         for (int p = 0; p < 4; p++)
         begin
            m = slot_map(q.ctrl.rate, q.ctrl.half, 2'(p), bit_idx[10:3]);
            tx_byte = mem[q.sel][buf_addr(1'b1, m.idx)];
            d.tsc[p] = in_range && m.act && valid_bit(q.valid, m.idx);
            d.tx_oe[p] = in_range && m.act && valid_bit(q.valid, m.idx);
            d.tx_d[p] = tx_byte[~bit_idx[2:0]];
         end
      end

      // dsp port
      d.rsp.rvalid = dsp_req.rd;
      if (dsp_req.rd)
      begin
         unique case (tgt)
            TGT_BUF:
            begin
               d.rsp.rdata = {q.prefix, buf_byte};
            end
            TGT_SET, TGT_CLR:
            begin
               d.rsp.rdata = q.valid[reg_sel];
            end
            TGT_PREFIX:
            begin
               d.rsp.rdata = {8'h00, q.prefix};
            end
            TGT_CTRL:
            begin
               d.rsp.rdata = {11'h000, q.sel, q.ctrl};
            end
            TGT_NONE:
            begin
               d.rsp.rdata = `RDATA_NONE;
            end
         endcase
      end

      if (dsp_req.wr)
      begin
         unique case (tgt)
            TGT_BUF:
            begin
               dsp_we = 1'b1;
            end
            TGT_SET:
            begin
               d.valid[reg_sel] = q.valid[reg_sel] | dsp_req.wdata;
            end
            TGT_CLR:
            begin
               d.valid[reg_sel] = q.valid[reg_sel] & ~dsp_req.wdata;
            end
            TGT_PREFIX:
            begin
               d.prefix = dsp_req.wdata[7:0];
            end
            TGT_CTRL:
            begin
               d.ctrl = ctrl_t'(dsp_req.wdata[3:0]);
            end
            TGT_NONE:
            begin
               dsp_we = 1'b0;
            end
         endcase
      end
   end

   // ==================================================
   // registers
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.valid <= {8{`VALID_RST}};
         q.prefix <= `PREFIX_RST;
         q.ctrl <= ctrl_t'(`CTRL_RST);
      end
      else
         q <= d;
   end

   // ==================================================
   // frame buffers: line uses sel, dsp uses the other
   always_ff @(posedge clk)
   begin
      for (int p = 0; p < 4; p++)
      begin
         if (rx_we[p])
            mem[q.sel][buf_addr(1'b0, rx_wa[p])] <= rx_wd[p];
      end
      if (dsp_we)
         mem[~q.sel][dsp_req.addr[7:0]] <= dsp_req.wdata[7:0];
   end

   assign serial_transmit_out = q.tx_d;
   assign serial_transmit_oe = q.tx_oe;
   assign slot_enable_out_pin = q.tsc;
   assign dsp_rsp = q.rsp;

endmodule // pcm_port_unit

// [test/pcm_port_unit_asserts.sv]
/*
 * port checker of the pcm port unit.
 * assumes clk rising edge and nrst synchronous, active low.
 */
`timescale 1ns/1ps
module pcm_port_unit_asserts
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic highway_bit_clock,
   input wire logic [3:0] serial_transmit_out,
   input wire logic [3:0] serial_transmit_oe,
   input wire logic [3:0] slot_enable_out_pin,
   input wire pcm_port_pkg::dsp_req_t dsp_req,
   input wire pcm_port_pkg::dsp_rsp_t dsp_rsp
);
   import pcm_port_pkg::*;
   logic bclk_q;
   logic [7:0] rise_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ====
   // cycles since the bit clock rose
   always_ff @(posedge clk)
   begin
      bclk_q <= highway_bit_clock;
      if (!nrst)
         rise_q <= 8'hff;
      else if (highway_bit_clock && !bclk_q)
         rise_q <= 8'h00;
      else if (rise_q != 8'hff)
         rise_q <= rise_q + 8'h01;
   end
   a_rvalid_after_rd: assert property (dsp_req.rd |=> dsp_rsp.rvalid)
      else $error("no rvalid after read");
   a_rvalid_only_rd: assert property (dsp_rsp.rvalid |-> $past(dsp_req.rd))
      else $error("rvalid without read");
   a_rdata_held: assert property (!$past(dsp_req.rd) |-> $stable(dsp_rsp.rdata))
      else $error("rdata moved without read");
   a_unmapped_zero: assert property
      (dsp_req.rd && dsp_req.addr[15:9] != 7'h50 |=> dsp_rsp.rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_pin_is_oe: assert property (slot_enable_out_pin == serial_transmit_oe)
      else $error("slot enable differs from driver enable");
   a_oe_on_edge: assert property ($changed(serial_transmit_oe) |-> rise_q <= 8'h08)
      else $error("enable moved off bit clock edge");
   a_data_on_edge: assert property ($changed(serial_transmit_out) |-> rise_q <= 8'h08)
      else $error("data moved off bit clock edge");
   a_quiet_reset: assert property ($rose(nrst) |-> serial_transmit_oe == 4'h0)
      else $error("driver on after reset");
endmodule // pcm_port_unit_asserts

// [test/pcm_highway_model.sv]
/*
 * highway model: free running bit clock, frame sync, receive octets,
 * captures slot 0 of port 0.
 * takes frame_bits bits per frame, two bit clocks per bit when dbl_mode is set.
 */
`timescale 1ns/1ps
module pcm_highway_model
(
   output logic highway_bit_clock,
   output logic highway_frame_sync,
   output logic [3:0] serial_receive_in,
   input wire logic [3:0] serial_transmit_out,
   input wire logic [3:0] serial_transmit_oe,
   input wire logic [3:0] slot_enable_out_pin,
   input wire logic dbl_mode,
   input wire logic [9:0] frame_bits,
   output logic [7:0] tx_byte,
   output logic [15:0] oe_trace,
   output logic [3:0] oe_seen,
   output logic [3:0] tsc_seen,
   output int frames
);
   localparam logic [7:0] RX_OCTET = 8'h3c;
   int cyc_n;
   int bit_n;
   int per_bit;
   int frame_len;
   logic [3:0] oe_acc;
   logic [3:0] tsc_acc;
   // ====
   // line timing: free running clock, mode taken at each frame start
   initial
   begin
      {highway_bit_clock, highway_frame_sync, serial_receive_in} = 6'h00;
      {tx_byte, oe_trace} = 24'h000000;
      {oe_seen, tsc_seen, oe_acc, tsc_acc} = 16'h0000;
      frames = 0;
      per_bit = 1;
      frame_len = 256;
      cyc_n = 255;
      bit_n = 0;
      #1000;
      forever
      begin
         #80 highway_bit_clock = 1'b1;
         cyc_n = cyc_n + 1;
         if (cyc_n >= frame_len)
         begin
            cyc_n = 0;
            per_bit = dbl_mode ? 2 : 1;
            frame_len = int'(frame_bits) * per_bit;
            frames = frames + 1;
            {oe_seen, tsc_seen} = {oe_acc, tsc_acc};
            {oe_acc, tsc_acc} = 8'h00;
         end
         bit_n = cyc_n / per_bit;
         highway_frame_sync = (cyc_n == frame_len - 1);
         serial_receive_in = {4{RX_OCTET[7 - bit_n % 8]}};
         #80 highway_bit_clock = 1'b0;
         oe_acc = oe_acc | serial_transmit_oe;
         tsc_acc = tsc_acc | slot_enable_out_pin;
         if (cyc_n % per_bit == per_bit - 1)
         begin
            if (bit_n < 16)
               oe_trace[bit_n] = serial_transmit_oe[0];
            if (bit_n < 8)
               tx_byte[7 - bit_n] = serial_transmit_out[0];
         end
      end
   end
endmodule // pcm_highway_model

// [test/pcm_port_unit_test.sv]
/*
 * bench of the pcm port unit: dsp reads and writes, highway traffic.
 * assumes the package, model and checker compiled before.
 */
`timescale 1ns/1ps
`include "pcm_port_cfg.svh"
module pcm_port_unit_test;
   import pcm_port_pkg::*;
   logic clk;
   logic nrst;
   logic bclk;
   logic fsync;
   logic [3:0] rxd;
   logic [3:0] txd;
   logic [3:0] txoe;
   dsp_req_t req;
   dsp_rsp_t rsp;
   logic [7:0] tx_byte;
   logic [15:0] oe_trace;
   logic [3:0] tsc;
   logic [3:0] oe_seen;
   logic [3:0] tsc_seen;
   logic dbl_mode;
   logic [9:0] frame_bits;
   int frames;
   int bad_count;
   int comparisons;
   int f;
   pcm_port_unit dut_u (.clk(clk), .nrst(nrst), .highway_bit_clock(bclk),
      .highway_frame_sync(fsync), .serial_receive_in(rxd), .serial_transmit_out(txd),
      .serial_transmit_oe(txoe), .slot_enable_out_pin(tsc), .dsp_req(req), .dsp_rsp(rsp));
   pcm_highway_model line_u (.highway_bit_clock(bclk), .highway_frame_sync(fsync),
      .serial_receive_in(rxd), .serial_transmit_out(txd), .serial_transmit_oe(txoe),
      .slot_enable_out_pin(tsc), .dbl_mode(dbl_mode), .frame_bits(frame_bits),
      .tx_byte(tx_byte), .oe_trace(oe_trace), .oe_seen(oe_seen), .tsc_seen(tsc_seen),
      .frames(frames));
   // ====
   // tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic dsp_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic dsp_rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      check({15'h0000, rsp.rvalid}, 16'h0001);
      check(rsp.rdata, exp);
   endtask
   task automatic wait_frames(input int n);
      f = frames;
      wait (frames == f + n);
      repeat (4) @(posedge clk);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ====
   // clock, tests, watchdog
   initial
   begin
      clk = 1'b0;
      forever
         #2.5 clk = ~clk;
   end
   initial
   begin
      nrst = 1'b0;
      req = '0;
      dbl_mode = 1'b0;
      frame_bits = 10'h100;
      bad_count = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++)
         dsp_rd(`VALID_SET_BASE + 16'(i), `VALID_RST);
      dsp_rd(16'hb000, `RDATA_NONE);
      dsp_wr(`VALID_SET_BASE + 16'h0003, 16'h8001);
      dsp_wr(`VALID_SET_BASE + 16'h0003, 16'h0100);
      dsp_rd(`VALID_CLR_BASE + 16'h0003, 16'h8101);
      dsp_wr(`VALID_CLR_BASE + 16'h0003, 16'h8000);
      dsp_rd(`VALID_SET_BASE + 16'h0003, 16'h0101);
      dsp_wr(`VALID_CLR_BASE + 16'h0003, 16'hffff);
      dsp_wr(`PREFIX_ADDR, 16'h00c3);
      dsp_rd(`PREFIX_ADDR, 16'h00c3);
      wait (frames >= 2);
      dsp_wr(16'ha080, 16'hff5a);
      dsp_rd(16'ha080, 16'hc35a);
      dsp_wr(`VALID_SET_BASE, 16'h0001);
      wait_frames(2);
      check({8'h00, tx_byte}, 16'h005a);
      check(oe_trace, 16'h00ff);
      dsp_rd(16'ha000, 16'hc33c);
      dsp_rd(16'ha020, 16'hc33c);
      dsp_wr(`VALID_CLR_BASE, 16'h0001);
      dsp_wr(`VALID_SET_BASE + 16'h0002, 16'h0001);
      dsp_wr(`VALID_SET_BASE + 16'h0006, 16'h0001);
      dsp_wr(16'ha080, 16'h00a5);
      dsp_wr(`CTRL_ADDR, 16'h0005);
      dbl_mode <= 1'b1;
      frame_bits <= 10'h200;
      wait_frames(2);
      check({8'h00, tx_byte}, 16'h00a5);
      check(oe_trace, 16'h0000);
      check({12'h000, oe_seen}, 16'h0005);
      check({12'h000, tsc_seen}, 16'h0005);
      dsp_rd(16'ha000, 16'hc33c);
      dsp_rd(16'ha040, 16'hc33c);
      results();
   end
   initial
   begin
      #450000;
      bad_count++;
      results();
   end
endmodule // pcm_port_unit_test

bind pcm_port_unit pcm_port_unit_asserts chk_u (.clk(clk), .nrst(nrst),
   .highway_bit_clock(highway_bit_clock), .serial_transmit_out(serial_transmit_out),
   .serial_transmit_oe(serial_transmit_oe), .slot_enable_out_pin(slot_enable_out_pin),
   .dsp_req(dsp_req), .dsp_rsp(dsp_rsp));
